/* fdc_fan_drive.v */
// Fan drive configuration, drive control, tach measurement and PWM output
// Assumes synchronous TACH_IN and an AXI4-Lite master on the same clock
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "fdc_regs.vh"

module fdc_fan_drive #(
  parameter MS_CYCLES = `FDC_MS_CYCLES,
  parameter TACH_REF_CYCLES = `FDC_TACH_REF_CYCLES
) (
  input wire CLK,
  input wire RST_N,
  input wire [7:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire TACH_IN,
  output wire PWM_OUT
);

  function mapped;
    input [5:0] idx;
    begin
      mapped = (idx == `FDC_IDX_SETTING) || (idx == `FDC_IDX_CONFIG) ||
               (idx == `FDC_IDX_STEP) || (idx == `FDC_IDX_VALID) ||
               (idx == `FDC_IDX_TARGET) || (idx == `FDC_IDX_READING);
    end
  endfunction

  function [10:0] upd_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: upd_ms = `FDC_UPD_MS_0;
        3'h1: upd_ms = `FDC_UPD_MS_1;
        3'h2: upd_ms = `FDC_UPD_MS_2;
        3'h3: upd_ms = `FDC_UPD_MS_3;
        3'h4: upd_ms = `FDC_UPD_MS_4;
        3'h5: upd_ms = `FDC_UPD_MS_5;
        3'h6: upd_ms = `FDC_UPD_MS_6;
        default: upd_ms = `FDC_UPD_MS_7;
      endcase
    end
  endfunction

  function [15:0] win_cnt;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: win_cnt = `FDC_WIN_RPM_0;
        2'h1: win_cnt = `FDC_WIN_RPM_1;
        2'h2: win_cnt = `FDC_WIN_RPM_2;
        default: win_cnt = `FDC_WIN_RPM_3;
      endcase
    end
  endfunction

  // Multiply by 1, 2, 4 or 8 with saturation
  function [15:0] weight;
    input [15:0] raw;
    input [1:0] rng;
    reg [18:0] w;
    begin
      w = {3'h0, raw} << rng;
      weight = (w[18:16] != 3'h0) ? 16'hffff : w[15:0];
    end
  endfunction

  reg [15:0] config_reg;
  reg [9:0] setting_reg;
  reg [7:0] step_reg;
  reg [7:0] valid_reg;
  reg [15:0] target_reg;
  reg [15:0] reading_reg;
  reg [9:0] drive_reg;
  reg signed [17:0] prev_err_reg;
  reg aw_held_reg;
  reg [5:0] aw_idx_reg;
  reg w_held_reg;
  reg [15:0] wdata_reg;
  reg [1:0] wstrb_reg;
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  reg rvalid_reg;
  reg [15:0] rdata_reg;
  reg [1:0] rresp_reg;
  reg [23:0] ms_cnt_reg;
  reg [10:0] upd_cnt_reg;
  reg [15:0] ref_cnt_reg;
  reg [15:0] period_reg;
  reg [2:0] tach_hist_reg;
  reg tach_filt_reg;
  reg tach_prev_reg;
  reg [9:0] pwm_cnt_reg;
  reg pwm_reg;

  wire ramp_en = config_reg[`FDC_CFG_RAMP];
  wire bypass = config_reg[`FDC_CFG_BYPASS];
  wire [1:0] derivative_option = config_reg[`FDC_CFG_DER_HI:`FDC_CFG_DER_LO];
  wire [1:0] win_sel = config_reg[`FDC_CFG_WIN_HI:`FDC_CFG_WIN_LO];
  wire polarity = config_reg[`FDC_CFG_POL];
  wire loop_en = config_reg[`FDC_CFG_LOOP];
  wire [1:0] rng = config_reg[`FDC_CFG_RNG_HI:`FDC_CFG_RNG_LO];
  wire [2:0] upd_sel = config_reg[`FDC_CFG_UPD_HI:`FDC_CFG_UPD_LO];

  // Output port assigns and bus write side
  assign S_AXI_AWREADY = !aw_held_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_held_reg && !bvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = {16'h0000, rdata_reg};
  assign PWM_OUT = pwm_reg;

  wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  wire [15:0] lane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  wire [15:0] cfg_merge = (config_reg & ~lane_mask) | (wdata_reg & lane_mask);
  wire [15:0] set_merge = ({setting_reg, 6'h00} & ~lane_mask) | (wdata_reg & lane_mask);
  wire [15:0] tgt_merge = (target_reg & ~lane_mask) | (wdata_reg & lane_mask);

  always @(posedge CLK) begin
    if (!RST_N) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
      w_held_reg <= 1'b0;
      wdata_reg <= 16'h0000;
      wstrb_reg <= 2'b00;
      bvalid_reg <= 1'b0;
      bresp_reg <= `FDC_RESP_OKAY;
      config_reg <= `FDC_CFG_RST;
      setting_reg <= 10'h000;
      step_reg <= `FDC_STEP_RST;
      valid_reg <= `FDC_VALID_RST;
      target_reg <= `FDC_TARGET_RST;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg <= S_AXI_AWADDR[7:2];
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        wdata_reg <= S_AXI_WDATA[15:0];
        wstrb_reg <= S_AXI_WSTRB[1:0];
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= mapped(aw_idx_reg) ? `FDC_RESP_OKAY : `FDC_RESP_SLVERR;
        case (aw_idx_reg)
          `FDC_IDX_CONFIG: config_reg <= cfg_merge & `FDC_CFG_WMASK;
          `FDC_IDX_SETTING: begin
            if (!loop_en)
              setting_reg <= set_merge[15:6];
          end
          `FDC_IDX_STEP: begin
            if (wstrb_reg[0])
              step_reg <= wdata_reg[7:0];
          end
          `FDC_IDX_VALID: begin
            if (wstrb_reg[0])
              valid_reg <= wdata_reg[7:0];
          end
          `FDC_IDX_TARGET: target_reg <= tgt_merge;
          default: begin
          end
        endcase
      end else if (bvalid_reg && S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Bus read side
  always @(posedge CLK) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      rresp_reg <= `FDC_RESP_OKAY;
    end else if (S_AXI_ARVALID && !rvalid_reg) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= mapped(S_AXI_ARADDR[7:2]) ? `FDC_RESP_OKAY : `FDC_RESP_SLVERR;
      case (S_AXI_ARADDR[7:2])
        `FDC_IDX_CONFIG: rdata_reg <= config_reg & `FDC_CFG_WMASK;
        `FDC_IDX_SETTING: rdata_reg <= {loop_en ? drive_reg : setting_reg, 6'h00};
        `FDC_IDX_STEP: rdata_reg <= {8'h00, step_reg};
        `FDC_IDX_VALID: rdata_reg <= {8'h00, valid_reg};
        `FDC_IDX_TARGET: rdata_reg <= target_reg;
        `FDC_IDX_READING: rdata_reg <= reading_reg;
        default: rdata_reg <= 16'h0000;
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Millisecond divider and update interval
  wire ms_tick = (ms_cnt_reg == MS_CYCLES - 1);
  wire upd_tick = ms_tick && (upd_cnt_reg >= upd_ms(upd_sel) - 11'h001);

  always @(posedge CLK) begin
    if (!RST_N) begin
      ms_cnt_reg <= 24'h000000;
      upd_cnt_reg <= 11'h000;
    end else begin
      ms_cnt_reg <= ms_tick ? 24'h000000 : ms_cnt_reg + 24'h000001;
      if (upd_tick)
        upd_cnt_reg <= 11'h000;
      else if (ms_tick)
        upd_cnt_reg <= upd_cnt_reg + 11'h001;
    end
  end

  // Tach filter and period measurement
  wire tach_level = bypass ? TACH_IN : tach_filt_reg;
  wire ref_tick = (ref_cnt_reg == TACH_REF_CYCLES - 1);

  always @(posedge CLK) begin
    if (!RST_N) begin
      tach_hist_reg <= 3'h0;
      tach_filt_reg <= 1'b0;
      tach_prev_reg <= 1'b0;
      ref_cnt_reg <= 16'h0000;
      period_reg <= 16'h0000;
      reading_reg <= 16'hffff;
    end else begin
      tach_hist_reg <= {tach_hist_reg[1:0], TACH_IN};
      if (tach_hist_reg == 3'h7)
        tach_filt_reg <= 1'b1;
      else if (tach_hist_reg == 3'h0)
        tach_filt_reg <= 1'b0;
      tach_prev_reg <= tach_level;
      ref_cnt_reg <= ref_tick ? 16'h0000 : ref_cnt_reg + 16'h0001;
      if (tach_level && !tach_prev_reg) begin
        reading_reg <= weight(period_reg, rng);
        period_reg <= 16'h0000;
      end else if (ref_tick && period_reg != 16'hffff) begin
        period_reg <= period_reg + 16'h0001;
      end else if (period_reg == 16'hffff) begin
        reading_reg <= 16'hffff;
      end
    end
  end

  // Closed-loop next drive
  wire [15:0] valid_limit = weight({valid_reg, 8'h00}, rng);
  wire stalled = reading_reg > valid_limit;
  wire signed [17:0] err = $signed({2'b00, reading_reg}) - $signed({2'b00, weight(target_reg, rng)});
  wire signed [17:0] win = $signed({2'b00, win_cnt(win_sel)});
  wire signed [17:0] step_s = $signed({10'h000, step_reg});
  reg signed [17:0] delta;
  reg signed [17:0] sum;
  reg [9:0] loop_next;

  always @* begin
    delta = err >>> 2;
    case (derivative_option)
      2'h0: delta = err >>> 2;
      default: delta = (err >>> 2) + (err - prev_err_reg);
    endcase
    if (derivative_option != 2'h2) begin
      if (delta > step_s)
        delta = step_s;
      else if (delta < -step_s)
        delta = -step_s;
    end
    sum = $signed({8'h00, drive_reg}) + delta;
    if (stalled)
      loop_next = `FDC_DRIVE_MAX;
    else if (err <= win && err >= -win)
      loop_next = drive_reg;
    else if (sum < 0)
      loop_next = 10'h000;
    else if (sum > $signed({8'h00, `FDC_DRIVE_MAX}))
      loop_next = `FDC_DRIVE_MAX;
    else
      loop_next = sum[9:0];
  end

  // Manual ramp next drive
  wire [9:0] step10 = {2'b00, step_reg};
  reg [9:0] ramp_next;

  always @* begin
    ramp_next = setting_reg;
    if (setting_reg > drive_reg && setting_reg - drive_reg > step10)
      ramp_next = drive_reg + step10;
    else if (setting_reg < drive_reg && drive_reg - setting_reg > step10)
      ramp_next = drive_reg - step10;
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      drive_reg <= 10'h000;
      prev_err_reg <= 18'sh00000;
    end else if (loop_en) begin
      if (upd_tick) begin
        drive_reg <= loop_next;
        prev_err_reg <= err;
      end
    end else if (ramp_en) begin
      if (upd_tick)
        drive_reg <= ramp_next;
    end else begin
      drive_reg <= setting_reg;
    end
  end

  // PWM output, period of 1023 clocks
  always @(posedge CLK) begin
    if (!RST_N) begin
      pwm_cnt_reg <= 10'h000;
      pwm_reg <= 1'b0;
    end else begin
      pwm_cnt_reg <= (pwm_cnt_reg == `FDC_PWM_TOP) ? 10'h000 : pwm_cnt_reg + 10'h001;
      pwm_reg <= (pwm_cnt_reg < drive_reg) ^ polarity;
    end
  end

endmodule

/* fdc_fan_drive_properties.sv */
// Checker for the fan drive register bus and reserved bit
// Assumes it is bound to fdc_fan_drive and sees only its ports
`timescale 1ns/1ps
module fdc_fan_drive_properties (
  input wire CLK,
  input wire RST_N,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [7:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0] S_AXI_RRESP,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  reg [7:0] ra_reg;
  // Address of the read under way
  always @(posedge CLK) begin
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      ra_reg <= S_AXI_ARADDR;
    end
  end
  property p_ar_answer;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_ar_answer: assert property (p_ar_answer) else $error("read not answered");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_r_drop;
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
  endproperty
  a_r_drop: assert property (p_r_drop) else $error("read valid stuck");
  property p_ar_block;
    S_AXI_RVALID |-> !S_AXI_ARREADY;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_b_answer;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID;
  endproperty
  a_b_answer: assert property (p_b_answer) else $error("write not answered");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  property p_rsv_zero;
    S_AXI_RVALID && ra_reg == 8'h08 |-> !S_AXI_RDATA[8] && S_AXI_RDATA[31:16] == 16'h0000;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set");
  property p_unmapped;
    S_AXI_RVALID && ra_reg == 8'h3c |-> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  c_cfg_read: cover property (S_AXI_RVALID && S_AXI_RREADY && ra_reg == 8'h08);
  c_unmapped: cover property (S_AXI_RVALID && S_AXI_RRESP == 2'h2);
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule
bind fdc_fan_drive fdc_fan_drive_properties u_fdc_fan_drive_properties (
  .CLK(CLK),
  .RST_N(RST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR),
  .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY)
);

/* fdc_fan_drive_tb.sv */
// Testbench: register access, PWM duty, ramping and tach reading
// Assumes the fan model drives the tach input
`timescale 1ns/1ps
module fdc_fan_drive_tb;
  localparam [79:0] SETS = {16'hffc0, 16'h0000, 16'hffc0, 16'h8000, 16'h0000};
  localparam [54:0] EH = {11'h000, 11'h3ff, 11'h3ff, 11'h200, 11'h000};
  localparam [4:0] POLS = 5'b11000;
  reg CLK, RST_N;
  reg [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  reg [31:0] S_AXI_WDATA;
  reg [3:0] S_AXI_WSTRB;
  reg S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY;
  wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, TACH_IN, PWM_OUT;
  wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0] S_AXI_RDATA;
  integer n_errors, checks_done, cyc, i;
  reg [31:0] d, h;
  reg [1:0] rs;
  fdc_fan_drive #(.MS_CYCLES(4), .TACH_REF_CYCLES(2)) u_fdc_fan_drive (
    .CLK(CLK),
    .RST_N(RST_N),
    .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR),
    .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA),
    .S_AXI_RRESP(S_AXI_RRESP),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY),
    .TACH_IN(TACH_IN),
    .PWM_OUT(PWM_OUT)
  );
  fdc_fan_model u_fdc_fan_model (.CLK(CLK), .TACH_IN(TACH_IN));
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  task check(input [31:0] seen, input [31:0] exp, input string what);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("wrong value %0s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task tally_and_finish;
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      tally_and_finish;
    end
  end
  task wr(input [7:0] a, input [15:0] v);
    reg aw, w;
    begin
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {16'h0000, v};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      S_AXI_BREADY <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      while (!(aw && w)) begin
        @(posedge CLK);
        if (!aw && S_AXI_AWREADY) begin
          aw = 1'b1;
          S_AXI_AWVALID <= 1'b0;
        end
        if (!w && S_AXI_WREADY) begin
          w = 1'b1;
          S_AXI_WVALID <= 1'b0;
        end
      end
      do @(posedge CLK); while (!S_AXI_BVALID);
      rs = S_AXI_BRESP;
      S_AXI_BREADY <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      S_AXI_RREADY <= 1'b1;
      do @(posedge CLK); while (!S_AXI_ARREADY);
      S_AXI_ARVALID <= 1'b0;
      do @(posedge CLK); while (!S_AXI_RVALID);
      d = S_AXI_RDATA;
      rs = S_AXI_RRESP;
      S_AXI_RREADY <= 1'b0;
    end
  endtask
  // Count PWM high cycles over one full period
  task duty;
    begin
      h = 0;
      repeat (1023) begin
        @(posedge CLK);
        h = h + PWM_OUT;
      end
    end
  endtask
  initial begin
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    S_AXI_WSTRB = 4'h3;
    RST_N = 1'b0;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    rd(8'h08);
    check(d, 32'h0000342b, "config reset");
    check({30'h0, rs}, 32'h0, "read response");
    wr(8'h08, 16'hffff);
    rd(8'h08);
    check(d, 32'h0000feff, "config bit 8");
    for (i = 0; i < 5; i = i + 1) begin
      wr(8'h08, {6'h0d, POLS[i], 9'h02b});
      wr(8'h00, SETS[i*16+:16]);
      repeat (4) @(posedge CLK);
      duty;
      check(h, {21'h0, EH[i*11+:11]}, "pwm duty");
    end
    rd(8'h00);
    check(d, 32'h0000ffc0, "setting under polarity");
    wr(8'h00, 16'h0000);
    wr(8'h08, 16'hb428);
    wr(8'h00, 16'hffc0);
    duty;
    check({31'h0, h <= 64}, 32'h1, "ramp duty early");
    duty;
    check({31'h0, h >= 32 && h <= 128}, 32'h1, "ramp duty later");
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h08, {9'h068, i[1:0], 5'h0b});
      repeat (300) @(posedge CLK);
      rd(8'h38);
      check({31'h0, d >= (32'd18 << i) && d <= (32'd22 << i)}, 32'h1, "tach reading");
    end
    wr(8'h08, 16'h742b);
    repeat (300) @(posedge CLK);
    rd(8'h38);
    check({31'h0, d <= 32}, 32'h1, "unfiltered tach");
    wr(8'h00, 16'h0000);
    wr(8'h1c, 16'h0001);
    rd(8'h1c);
    check(d, 32'h00000001, "step readback");
    wr(8'h30, 16'h0000);
    check({30'h0, rs}, 32'h0, "write response");
    // Closed loop, no derivative, zero window: one step per update
    wr(8'h08, 16'h0088);
    rd(8'h00);
    h = d;
    repeat (900) @(posedge CLK);
    rd(8'h00);
    check({31'h0, d > h && ((d - h) >> 6) <= 3}, 32'h1, "step limited loop");
    // Derivative option 2 ignores the step limit
    wr(8'h08, 16'h2088);
    rd(8'h00);
    h = d;
    repeat (900) @(posedge CLK);
    rd(8'h00);
    check({31'h0, d > h && ((d - h) >> 6) > 3}, 32'h1, "unclamped loop");
    // Widest window holds the drive
    wr(8'h08, 16'h0c88);
    rd(8'h00);
    h = d;
    repeat (900) @(posedge CLK);
    rd(8'h00);
    check(d, h, "window hold");
    rd(8'h3c);
    check(d, 32'h0, "unmapped data");
    check({30'h0, rs}, 32'h2, "unmapped read response");
    wr(8'h3c, 16'h1234);
    check({30'h0, rs}, 32'h2, "unmapped write response");
    tally_and_finish;
  end
endmodule

/* fdc_fan_model.sv */
// Fan model: tach with a 40-clock period and one noise pulse in each low phase
// Assumes a steady fan speed whatever the drive
`timescale 1ns/1ps
module fdc_fan_model (
  input wire CLK,
  output reg TACH_IN
);
  reg [5:0] cnt_reg;
  initial begin
    cnt_reg = 6'h00;
    TACH_IN = 1'b1;
  end
  always @(posedge CLK) begin
    cnt_reg <= (cnt_reg == 6'h27) ? 6'h00 : cnt_reg + 6'h01;
    TACH_IN <= (cnt_reg < 6'h14) || (cnt_reg == 6'h1e);
  end
endmodule

/* fdc_regs.vh */
// Register map, field positions, reset values and timing counts of the fan drive block
// Assumes a 10 MHz system clock and word-aligned AXI4-Lite access
`ifndef FDC_REGS_VH
`define FDC_REGS_VH
`define FDC_IDX_SETTING 6'h00
`define FDC_IDX_CONFIG 6'h02
`define FDC_IDX_STEP 6'h07
`define FDC_IDX_VALID 6'h09
`define FDC_IDX_TARGET 6'h0c
`define FDC_IDX_READING 6'h0e
`define FDC_CFG_RAMP 15
`define FDC_CFG_BYPASS 14
`define FDC_CFG_DER_HI 13
`define FDC_CFG_DER_LO 12
`define FDC_CFG_WIN_HI 11
`define FDC_CFG_WIN_LO 10
`define FDC_CFG_POL 9
`define FDC_CFG_LOOP 7
`define FDC_CFG_RNG_HI 6
`define FDC_CFG_RNG_LO 5
`define FDC_CFG_UPD_HI 2
`define FDC_CFG_UPD_LO 0
`define FDC_CFG_RST 16'h342b
`define FDC_CFG_WMASK 16'hfeff
`define FDC_SET_WMASK 16'hffc0
`define FDC_STEP_RST 8'h10
`define FDC_VALID_RST 8'hf5
`define FDC_TARGET_RST 16'hffff
`define FDC_DRIVE_MAX 10'h3ff
`define FDC_PWM_TOP 10'h3fe
`define FDC_WIN_RPM_0 16'h0000
`define FDC_WIN_RPM_1 16'h0032
`define FDC_WIN_RPM_2 16'h0064
`define FDC_WIN_RPM_3 16'h00c8
`define FDC_UPD_MS_0 11'h064
`define FDC_UPD_MS_1 11'h0c8
`define FDC_UPD_MS_2 11'h12c
`define FDC_UPD_MS_3 11'h190
`define FDC_UPD_MS_4 11'h1f4
`define FDC_UPD_MS_5 11'h320
`define FDC_UPD_MS_6 11'h4b0
`define FDC_UPD_MS_7 11'h640
`define FDC_CLK_NS 100
`define FDC_MS_NS 1000000
`define FDC_TACH_REF_NS 100000
`define FDC_MS_CYCLES (`FDC_MS_NS / `FDC_CLK_NS)
`define FDC_TACH_REF_CYCLES (`FDC_TACH_REF_NS / `FDC_CLK_NS)
`define FDC_RESP_OKAY 2'b00
`define FDC_RESP_SLVERR 2'b10
`endif
